// *** hdl/wurun_consts.svh ***
// Register map, field positions, reset values and timing counts of the run-mode sequencer
`ifndef WURUN_CONSTS_SVH
`define WURUN_CONSTS_SVH
// Byte offsets
`define OFS_CTRL      4'h0
`define OFS_TMO_A     4'h4
`define OFS_TMO_B     4'h8
`define OFS_EXTCMD    4'hC
`define OFS_STATUS    5'h10
`define OFS_CHREC     5'h14
`define OFS_EVMASK    5'h18
// Control fields
`define CT_MASTER_MODE_SELECT       0
`define CT_MT         1
`define CT_PMOD       2
`define CT_RETEOM     3
`define CT_EOM_TO_A   4
`define CT_TMO_TO_A   5
`define CT_PARALLEL_WAKEUP_ENABLE      6
`define CT_KEEPFR     7
`define CT_COO        8
`define CT_FCLR_CYC   9
`define CT_FCLR_FS    10
`define CT_EXTERNAL_PROCESSING_MODE    11
`define CT_MULTI      12
`define CTRL_RST      32'h0000_0000
`define TMO_RST       32'h0000_0000
// External command bits
`define XC_TMO        0
`define XC_EOM        1
// Timeout tick: 100 us at a 100 ns clock
`define CLK_NS        100
`define TICK_NS       100000
`define TICK_CYC      (`TICK_NS / `CLK_NS)
`endif

// *** hdl/wurun_pkg.sv ***
// Types shared by the run-mode sequencer
package wurun_pkg;
  typedef enum logic [1:0] {
    S_HOST    = 2'b00,
    S_POLL    = 2'b01,
    S_WAIT    = 2'b11,
    S_PAYLOAD = 2'b10
  } seq_state_t;
  typedef struct packed {
    logic wakeup;
    logic sync;
    logic frame_start;
    logic tag;
    logic end_of_message;
    logic fifo_locked;
    logic last_cfg;
  } rx_ev_t;
  typedef struct packed {
    logic restart;
    logic next;
    logic go_off;
  } poll_cmd_t;
endpackage

// *** hdl/wurun_seq.sv ***
// Wake-up run-mode sequencer with Wishbone register slave
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "wurun_consts.svh"
module wurun_seq
  import wurun_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Receive path events
  input  wire rx_ev_t      rx_i,
  // Sequencer controls
  output seq_state_t       state_o,
  output logic             cfg_o,
  output logic             mod_o,
  output logic             fifo_clear_o,
  output logic             framer_clear_o,
  output logic             wu_search_o,
  output poll_cmd_t        poll_o,
  output logic             host_event_o
);

  seq_state_t  state_q, state_d;
  logic [31:0] ctrl_q, tmo_a_q, tmo_b_q;
  logic [2:0]  sticky_q, mask_q;
  logic [1:0]  chrec_q;
  logic        cfg_q, ext_to_q, ext_eom_q;
  logic        ack_q, wr;
  logic [15:0] tick_cnt_q;
  logic        tick_q;
  logic [7:0]  phase_cnt_q, sl_cnt_q;
  logic        pwu_armed_q, pwu_done_q, pwu_act, sync_q;
  logic        in_run, ext_en, ext_to, ext_eom, timeout, eom_hit, leave, resume_a;
  logic        enter, pwu_wu, frame_ok, reload;
  logic [31:0] tmo;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Event decode
  always_comb begin
    in_run   = (state_q == S_WAIT) || (state_q == S_PAYLOAD);
    ext_en   = ctrl_q[`CT_EXTERNAL_PROCESSING_MODE];
    ext_to   = ext_to_q && ext_en && in_run;
    ext_eom  = ext_eom_q && ext_en && in_run;
    tmo      = cfg_q ? tmo_b_q : tmo_a_q;
    timeout  = ext_to
            || (in_run && tmo[7:0] != 8'h00 && sl_cnt_q >= tmo[7:0])
            || (state_q == S_WAIT && tmo[15:8] != 8'h00 && phase_cnt_q >= tmo[15:8])
            || (state_q == S_PAYLOAD && tmo[23:16] != 8'h00 && phase_cnt_q >= tmo[23:16]);
    eom_hit  = (state_q == S_PAYLOAD && rx_i.end_of_message && !ext_en) || ext_eom;
    leave    = in_run && (timeout || (eom_hit && ctrl_q[`CT_RETEOM]));
    resume_a = timeout ? ctrl_q[`CT_TMO_TO_A] : ctrl_q[`CT_EOM_TO_A];
    enter    = state_q == S_POLL && rx_i.wakeup;
    pwu_act  = pwu_armed_q && !pwu_done_q && ctrl_q[`CT_PARALLEL_WAKEUP_ENABLE] && state_q == S_WAIT
            && rx_i.sync && (ctrl_q[`CT_MT] == ctrl_q[`CT_PMOD]);
    pwu_wu   = pwu_act && rx_i.wakeup;
    frame_ok = state_q == S_WAIT && rx_i.frame_start;
    reload   = (eom_hit && !leave) || pwu_wu;
  end

  // Next state; leaving the host mode is the host's own choice
  always_comb begin
    state_d = state_q;
    if (!ctrl_q[`CT_MASTER_MODE_SELECT]) begin
      state_d = S_HOST;
    end else begin
      case (state_q)
        S_HOST:    state_d = S_POLL;
        S_POLL:    if (enter) state_d = S_WAIT;
        S_WAIT: begin
          if (leave) begin
            state_d = S_POLL;
          end else if (frame_ok) begin
            state_d = S_PAYLOAD;
          end
        end
        S_PAYLOAD: begin
          if (leave) begin
            state_d = S_POLL;
          end else if (eom_hit) begin
            state_d = S_WAIT;
          end
        end
        default:   state_d = S_HOST;
      endcase
    end
  end

  // State register and modulation follow the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_HOST;
      mod_o   <= 1'b0;
    end else begin
      state_q <= state_d;
      mod_o   <= (state_d == S_WAIT || state_d == S_PAYLOAD) ? ctrl_q[`CT_MT] : ctrl_q[`CT_PMOD];
    end
  end

  // Configuration pointer; selects the timeouts, tmo_a_q when clear and tmo_b_q when set
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_q[`CT_MASTER_MODE_SELECT]) begin
      cfg_q <= 1'b0;
    end else if (leave) begin
      cfg_q <= resume_a ? 1'b0 : (ctrl_q[`CT_MULTI] & ~cfg_q);
    end
  end

  // Polling timer commands, one-cycle pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_o <= '0;
    end else begin
      poll_o.restart <= leave && (resume_a || ctrl_q[`CT_COO]);
      poll_o.next    <= leave && !resume_a;
      poll_o.go_off  <= leave && !resume_a && rx_i.last_cfg;
    end
  end

  // Timeout tick prescaler; long ticks keep the counters narrow
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_cnt_q == 16'(TICK_CYC - 1)) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
    tick_q <= !rst_i && tick_cnt_q == 16'(TICK_CYC - 1);
  end

  // Phase and sync-loss timers
  always_ff @(posedge clk_i) begin
    if (rst_i || !in_run || state_d != state_q || reload) begin
      phase_cnt_q <= 8'h00;
    end else if (tick_q && phase_cnt_q != 8'hFF) begin
      phase_cnt_q <= phase_cnt_q + 8'h01;
    end
    if (rst_i || !in_run || rx_i.sync || leave || reload) begin
      sl_cnt_q <= 8'h00;
    end else if (tick_q && sl_cnt_q != 8'hFF) begin
      sl_cnt_q <= sl_cnt_q + 8'h01;
    end
  end

  // FIFO and framer clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_clear_o   <= 1'b0;
      framer_clear_o <= 1'b0;
    end else begin
      fifo_clear_o   <= ((enter || pwu_wu) && ctrl_q[`CT_FCLR_CYC])
                     || (frame_ok && !rx_i.fifo_locked && ctrl_q[`CT_FCLR_FS]);
      framer_clear_o <= (enter || pwu_wu) && !ctrl_q[`CT_KEEPFR];
    end
  end

  // Parallel wake-up search: armed by a message end, one sync period long
  always_ff @(posedge clk_i) begin
    if (rst_i || !in_run) begin
      pwu_armed_q <= 1'b0;
      pwu_done_q  <= 1'b0;
    end else begin
      if (eom_hit) begin
        pwu_armed_q <= 1'b1;
      end
      if (ext_eom || pwu_wu) begin
        pwu_done_q <= 1'b0;
      end else if (pwu_armed_q && state_q == S_WAIT && !rx_i.sync && sync_q) begin
        pwu_done_q <= 1'b1;
      end
    end
    wu_search_o <= !rst_i && (state_d == S_POLL || (pwu_act && state_d == S_WAIT));
    sync_q      <= !rst_i && rx_i.sync;                                // Idle low, so no false fall after reset
  end

  // Channel record and sticky events; a new event beats its clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chrec_q      <= 2'b00;
      sticky_q     <= 3'b000;
      host_event_o <= 1'b0;
    end else begin
      if (eom_hit) begin
        chrec_q <= {mod_o, cfg_q};
      end
      for (int i = 0; i < 3; i++) begin
        if (wr && adr_i == `OFS_STATUS && sel_i[0] && dat_i[i]) begin
          sticky_q[i] <= 1'b0;
        end
      end
      if (frame_ok) sticky_q[0] <= 1'b1;
      if (state_q == S_PAYLOAD && rx_i.tag) sticky_q[1] <= 1'b1;
      if (eom_hit) sticky_q[2] <= 1'b1;
      host_event_o <= |(sticky_q & mask_q);
    end
  end

  // Wishbone slave: ack one cycle after request, write at the ack edge
  assign wr = cyc_i && stb_i && we_i && ack_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
      case (adr_i)
        5'(`OFS_CTRL):   dat_o <= ctrl_q;
        5'(`OFS_TMO_A):  dat_o <= tmo_a_q;
        5'(`OFS_TMO_B):  dat_o <= tmo_b_q;
        `OFS_STATUS:     dat_o <= {24'h00_0000, cfg_q, state_q, pwu_armed_q, pwu_done_q, sticky_q};
        `OFS_CHREC:      dat_o <= {30'h0000_0000, chrec_q};
        `OFS_EVMASK:     dat_o <= {29'h0000_0000, mask_q};
        default:         dat_o <= 32'h0000_0000;
      endcase
    end
  end
  assign ack_o = ack_q;

  // Software registers; commands are single-cycle strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= `CTRL_RST;
      tmo_a_q   <= `TMO_RST;
      tmo_b_q   <= `TMO_RST;
      mask_q    <= 3'b000;
      ext_to_q  <= 1'b0;
      ext_eom_q <= 1'b0;
    end else begin
      ext_to_q  <= wr && adr_i == 5'(`OFS_EXTCMD) && sel_i[0] && dat_i[`XC_TMO];
      ext_eom_q <= wr && adr_i == 5'(`OFS_EXTCMD) && sel_i[0] && dat_i[`XC_EOM];
      if (wr && adr_i == 5'(`OFS_CTRL)) ctrl_q <= merge(ctrl_q, dat_i, sel_i);
      if (wr && adr_i == 5'(`OFS_TMO_A)) tmo_a_q <= merge(tmo_a_q, dat_i, sel_i);
      if (wr && adr_i == 5'(`OFS_TMO_B)) tmo_b_q <= merge(tmo_b_q, dat_i, sel_i);
      if (wr && adr_i == `OFS_EVMASK && sel_i[0]) mask_q <= dat_i[2:0];
    end
  end

  assign state_o = state_q;
  assign cfg_o   = cfg_q;

  property p_wake_enter;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_POLL && rx_i.wakeup && ctrl_q[`CT_MASTER_MODE_SELECT]) |=> (state_q == S_WAIT && mod_o == ctrl_q[`CT_MT]);
  endproperty
  a_wake_enter: assert property (p_wake_enter) else $error("wake-up did not enter run");

  property p_tmo_leave;
    @(posedge clk_i) disable iff (rst_i)
    (in_run && timeout && ctrl_q[`CT_MASTER_MODE_SELECT]) |=> (state_q == S_POLL && phase_cnt_q == 8'h00);
  endproperty
  a_tmo_leave: assert property (p_tmo_leave) else $error("timeout did not leave run");

  property p_fifo_cyc;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_POLL && rx_i.wakeup && ctrl_q[`CT_FCLR_CYC]) |=> fifo_clear_o ##1 !fifo_clear_o;
  endproperty
  a_fifo_cyc: assert property (p_fifo_cyc) else $error("fifo not cleared at cycle start");

  property p_chrec;
    @(posedge clk_i) disable iff (rst_i)
    eom_hit |=> chrec_q[0] == $past(cfg_q);
  endproperty
  a_chrec: assert property (p_chrec) else $error("channel record wrong");

  property p_restart_a;
    @(posedge clk_i) disable iff (rst_i)
    (leave && resume_a) |=> (poll_o.restart && !poll_o.next && cfg_q == 1'b0);
  endproperty
  a_restart_a: assert property (p_restart_a) else $error("resume on A did not restart timer");

  property p_coo;
    @(posedge clk_i) disable iff (rst_i)
    (leave && ctrl_q[`CT_COO]) |=> poll_o.restart;
  endproperty
  a_coo: assert property (p_coo) else $error("constant on-off did not restart timer");

  property p_ext_gate;
    @(posedge clk_i) disable iff (rst_i)
    (ext_to_q && !ctrl_q[`CT_EXTERNAL_PROCESSING_MODE] && state_q == S_WAIT && !timeout && !frame_ok && ctrl_q[`CT_MASTER_MODE_SELECT])
      |=> state_q == S_WAIT;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external timeout honoured while disabled");

  property p_payload_no_wu;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_PAYLOAD) [*2] |-> !wu_search_o;
  endproperty
  a_payload_no_wu: assert property (p_payload_no_wu) else $error("wake-up search during payload");

  property p_keep_framer;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_POLL && rx_i.wakeup && ctrl_q[`CT_KEEPFR]) |=> !framer_clear_o;
  endproperty
  a_keep_framer: assert property (p_keep_framer) else $error("framer cleared despite keep bit");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not single cycle");

  property p_fifo_frame;
    @(posedge clk_i) disable iff (rst_i)
    (frame_ok && !rx_i.fifo_locked && ctrl_q[`CT_FCLR_FS]) |=> fifo_clear_o;
  endproperty
  a_fifo_frame: assert property (p_fifo_frame) else $error("fifo not cleared at frame start");

  property p_go_off;
    @(posedge clk_i) disable iff (rst_i)
    (leave && !resume_a && rx_i.last_cfg) |=> (poll_o.go_off && poll_o.next);
  endproperty
  a_go_off: assert property (p_go_off) else $error("last configuration did not go off");

  property p_eom_stay;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_PAYLOAD && eom_hit && !leave && ctrl_q[`CT_MASTER_MODE_SELECT])
      |=> (state_q == S_WAIT && phase_cnt_q == 8'h00);
  endproperty
  a_eom_stay: assert property (p_eom_stay) else $error("message end did not reload and stay");

  property p_int_eom_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_PAYLOAD && rx_i.end_of_message && ctrl_q[`CT_EXTERNAL_PROCESSING_MODE] && !ext_eom && !timeout && ctrl_q[`CT_MASTER_MODE_SELECT])
      |=> state_q == S_PAYLOAD;
  endproperty
  a_int_eom_ignored: assert property (p_int_eom_ignored) else $error("internal end used in external mode");

  property p_pwu_end;
    @(posedge clk_i) disable iff (rst_i)
    (pwu_done_q && state_q == S_WAIT && state_d == S_WAIT) |=> !wu_search_o;
  endproperty
  a_pwu_end: assert property (p_pwu_end) else $error("parallel search after sync loss");

endmodule
`default_nettype wire

// *** verif/wurun_host.sv ***
// Host side model: classic Wishbone master used by the bench
`timescale 1ns/10ps
`default_nettype none
module wurun_host (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [4:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  // Idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 5'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  // One classic cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released lines show no stale value
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
  // Commands spaced by whole bus cycles, well under a sync run
endmodule
`default_nettype wire

// *** verif/wurun_seq_test.sv ***
// Self-checking bench of the run-mode sequencer
`timescale 1ns/10ps
`default_nettype none
module wurun_seq_test;
  import wurun_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  rx_ev_t rx = '0;
  seq_state_t st;
  logic cfg, md, fclr, frclr, wus, hev, clr = 1'b0;
  poll_cmd_t pc;
  logic [4:0] seen = 5'h00;
  int bad_count = 0;
  int comparisons = 0;
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  wurun_host host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
                   .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  // Short tick keeps timeouts to a few cycles
  wurun_seq #(.TICK_CYC(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .rx_i(rx), .state_o(st),
    .cfg_o(cfg), .mod_o(md), .fifo_clear_o(fclr), .framer_clear_o(frclr), .wu_search_o(wus),
    .poll_o(pc), .host_event_o(hev));
  // One-cycle pulses are latched so a check never misses them
  always @(posedge clk_i) seen <= clr ? 5'h00 : seen | {fclr, frclr, pc};
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [4:0] e, input logic [4:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0000_0000, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One-cycle event on the receive path, pulse latch cleared first
  task automatic pulse(input rx_ev_t ev);
    @(posedge clk_i);
    clr <= 1'b1;
    rx  <= rx | ev;
    @(posedge clk_i);
    clr <= 1'b0;
    rx  <= rx & ~ev;
    settle(2);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk_pin("state", {3'h0, S_HOST}, {3'h0, st});
    rd(5'h1C, q);
    chk_reg("unmapped", 32'h0000_0000, q);
    $display("test reset done");
    // Polling, run modulation set, FIFO clear at cycle start, frame-start event unmasked
    wr(5'h18, 32'h0000_0001);
    wr(5'h00, 32'h0000_0203);
    settle(2);
    chk_pin("state", {3'h0, S_POLL}, {3'h0, st});
    chk_pin("wu_search", 5'h01, {4'h0, wus});
    pulse(rx_ev_t'(7'h40));
    chk_pin("state", {3'h0, S_WAIT}, {3'h0, st});
    chk_pin("mod", 5'h01, {4'h0, md});
    chk_pin("clears", 5'h18, seen);
    $display("test wakeup done");
    pulse(rx_ev_t'(7'h10));
    chk_pin("state", {3'h0, S_PAYLOAD}, {3'h0, st});
    chk_pin("host_event", 5'h01, {4'h0, hev});
    rd(5'h10, q);
    chk_reg("status", 32'h0000_0001, q & 32'h0000_0007);
    wr(5'h10, 32'h0000_0001);
    settle(2);
    chk_pin("host_event", 5'h00, {4'h0, hev});
    $display("test frame done");
    pulse(rx_ev_t'(7'h04));
    chk_pin("state", {3'h0, S_WAIT}, {3'h0, st});
    rd(5'h14, q);
    chk_reg("chrec", 32'h0000_0002, q);
    pulse(rx_ev_t'(7'h10));
    chk_pin("state", {3'h0, S_PAYLOAD}, {3'h0, st});
    pulse(rx_ev_t'(7'h04));
    $display("test repeat done");
    // External timeout refused without external processing
    wr(5'h0C, 32'h0000_0001);
    settle(3);
    chk_pin("state", {3'h0, S_WAIT}, {3'h0, st});
    wr(5'h00, 32'h0000_0A03);
    rx.last_cfg <= 1'b1;
    clr <= 1'b1;
    settle(1);
    clr <= 1'b0;
    wr(5'h0C, 32'h0000_0001);
    settle(3);
    chk_pin("state", {3'h0, S_POLL}, {3'h0, st});
    chk_pin("poll", 5'h03, seen);
    rx.last_cfg <= 1'b0;
    $display("test external done");
    // Sync-loss timeout of one tick, resume on configuration A
    wr(5'h00, 32'h0000_0223);
    wr(5'h04, 32'h0000_0001);
    pulse(rx_ev_t'(7'h40));
    chk_pin("state", {3'h0, S_WAIT}, {3'h0, st});
    for (int i = 0; i < 60 && st !== S_POLL; i++) settle(1);
    // Poll pulse reaches the latch one edge after the state change
    settle(1);
    chk_pin("state", {3'h0, S_POLL}, {3'h0, st});
    chk_pin("poll", 5'h04, seen & 5'h07);
    chk_pin("cfg", 5'h00, {4'h0, cfg});
    $display("test timeout done");
    // Two configurations, kept framer, FIFO clear at frame start, constant on-off, return on end
    wr(5'h04, 32'h0000_0000);
    wr(5'h10, 32'h0000_0007);
    wr(5'h18, 32'h0000_0002);
    wr(5'h00, 32'h0000_158B);
    pulse(rx_ev_t'(7'h40));
    chk_pin("clears", 5'h00, seen);
    pulse(rx_ev_t'(7'h12));
    chk_pin("state", {3'h0, S_PAYLOAD}, {3'h0, st});
    chk_pin("clears", 5'h00, seen);
    chk_pin("host_event", 5'h00, {4'h0, hev});
    pulse(rx_ev_t'(7'h08));
    chk_pin("host_event", 5'h01, {4'h0, hev});
    pulse(rx_ev_t'(7'h04));
    chk_pin("state", {3'h0, S_POLL}, {3'h0, st});
    chk_pin("poll", 5'h06, seen);
    chk_pin("cfg", 5'h01, {4'h0, cfg});
    pulse(rx_ev_t'(7'h40));
    pulse(rx_ev_t'(7'h10));
    chk_pin("clears", 5'h10, seen);
    pulse(rx_ev_t'(7'h04));
    chk_pin("cfg", 5'h00, {4'h0, cfg});
    rd(5'h14, q);
    chk_reg("chrec", 32'h0000_0003, q);
    $display("test multi done");
    // External processing: internal end ignored, command ends message, parallel search
    wr(5'h00, 32'h0000_0841);
    pulse(rx_ev_t'(7'h40));
    pulse(rx_ev_t'(7'h10));
    pulse(rx_ev_t'(7'h04));
    chk_pin("state", {3'h0, S_PAYLOAD}, {3'h0, st});
    wr(5'h0C, 32'h0000_0002);
    settle(2);
    chk_pin("state", {3'h0, S_WAIT}, {3'h0, st});
    rd(5'h10, q);
    chk_reg("status", 32'h0000_0074, q & 32'h0000_007C);
    rx.sync <= 1'b1;
    settle(2);
    chk_pin("wu_search", 5'h01, {4'h0, wus});
    @(posedge clk_i);
    rx.sync <= 1'b0;
    settle(2);
    @(posedge clk_i);
    rx.sync <= 1'b1;
    settle(2);
    chk_pin("wu_search", 5'h00, {4'h0, wus});
    clr <= 1'b1;
    settle(1);
    clr <= 1'b0;
    wr(5'h04, 32'h0000_0100);
    for (int i = 0; i < 60 && st !== S_POLL; i++) settle(1);
    settle(1);
    chk_pin("state", {3'h0, S_POLL}, {3'h0, st});
    chk_pin("poll", 5'h02, seen & 5'h07);
    rx.sync <= 1'b0;
    $display("test external end done");
    wr(5'h00, 32'h0000_0000);
    settle(2);
    chk_pin("state", {3'h0, S_HOST}, {3'h0, st});
    $display("test host done");
    end_sim;
  end
endmodule
`default_nettype wire
